/* hdl/hdlc_rx_pkg.sv */
// What this block does
// - empty flag high exactly when FIFO empty
// - overwrite flags, resets FIFO, clears link/end flags
// - first opening flag or abort sets link-change
// - link-change clears on read, overwrite, disable
// - packet-end set on final byte; cleared likewise
// - last-read byte status: data, active, abort codes
// - final byte status: integer and FCS result codes
// - event flag collects all sources; read clears
// - data read pops one byte, LSB first
// - primary pattern register resets to all ones
// - secondary pattern register resets to all ones
// - two receivers per channel, selector bit 6
// - eight channel copies at stride 080 hex
// - address match filter on first frame byte
// - threshold interrupt persists until FIFO empty
// - disable clears FIFO, interrupts; enable hunts flag
// - interrupt pin on event flag rising edge
`default_nettype none
package hdlc_rx_pkg;
	localparam int DATA_W = 8;                       // register data width
	localparam int ADDR_W = 10;                      // register address width
	localparam int OFS_W = 7;                        // offset inside a channel window
	localparam logic [ADDR_W-1:0] OFS_SELECT = 10'h00d;   // instance selector register
	localparam logic [ADDR_W-1:0] CHANNEL_STRIDE = 10'h080;
	localparam logic [OFS_W-1:0] OFS_CONFIG = 7'h54;
	localparam logic [OFS_W-1:0] OFS_INTCTL = 7'h55;
	localparam logic [OFS_W-1:0] OFS_STATUS = 7'h56;
	localparam logic [OFS_W-1:0] OFS_DATA = 7'h57;
	localparam logic [OFS_W-1:0] OFS_PRIMARY = 7'h58;
	localparam logic [OFS_W-1:0] OFS_SECONDARY = 7'h59;
	localparam logic [OFS_W-1:0] OFS_IRQ_PEND = 7'h5a;
	localparam logic [OFS_W-1:0] OFS_IRQ_MASK = 7'h5b;
	// field positions
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_TR_BIT = 1;
	localparam int CFG_MM_BIT = 2;
	localparam int CFG_MEN_BIT = 3;
	localparam int ICTL_IRQ_OUTPUT_ENABLE_BIT = 7;
	localparam int SEL_LSB = 6;
	localparam int ST_FE_BIT = 7;
	localparam int ST_OVR_BIT = 6;
	localparam int ST_LINK_STATE_CHANGE_FLAG_BIT = 5;
	localparam int ST_PACKET_END_FLAG_BIT = 4;
	localparam int ST_RECEIVER_EVENT_FLAG_BIT = 0;
	// reset values
	localparam logic [7:0] PATTERN_RST = 8'hff;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	// byte status codes
	localparam logic [2:0] PBS_DATA = 3'h0;
	localparam logic [2:0] PBS_ACTIVE = 3'h1;
	localparam logic [2:0] PBS_ABORT = 3'h2;
	localparam logic [2:0] PBS_END = 3'h4;          // bit0 non-integer, bit1 fcs error
	// line coding
	localparam logic [7:0] FLAG_BYTE = 8'h7e;
	localparam logic [2:0] STUFF_ONES = 3'h5;
	localparam logic [2:0] ABORT_ONES = 3'h6;       // ones seen before the seventh
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hf0b8;
	localparam logic [7:0] THRESH_ZERO_LEVEL = 8'h80;
endpackage
`default_nettype wire

/* hdl/hdlc_receive_status_fifo.sv */
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module hdlc_rx_unit #(
	parameter int DEPTH = 128
) (
	// clock and reset
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_srst,
	// datalink bit stream
	input  wire logic                        i_bit,
	input  wire logic                        i_bit_valid,
	// register access
	input  wire logic                        i_sel,
	input  wire logic [hdlc_rx_pkg::OFS_W-1:0] i_ofs,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	input  wire logic [hdlc_rx_pkg::DATA_W-1:0] i_wdata,
	output logic      [hdlc_rx_pkg::DATA_W-1:0] o_rdata,
	// event flag rising while pin enabled
	output logic                             o_rise
);
	import hdlc_rx_pkg::*;
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic       cfg_en, cfg_tr, cfg_mm, cfg_men;   // configuration bits
	logic       irq_output_enable;                              // pin enable
	logic [6:0] thr;                               // fifo_threshold
	logic [7:0] pa, sa;                            // match patterns
	logic       wr_hit, rd_hit, st_rd, pop, flush;
	logic [2:0] ones;                              // run of ones
	logic [7:0] raw;                               // last raw bits
	logic [6:0] dly;                               // holds back a possible flag
	logic [2:0] dcnt, nbit;
	logic [7:0] asm_byte, pend;
	logic [15:0] crc;
	logic       link_up, in_frame, drop, first, pend_v;
	logic       wr_req;                            // one-cycle write to fifo
	logic [10:0] wr_word;                          // {tag, byte}
	logic [10:0] mem [DEPTH];
	logic [PTR_W-1:0] wptr, rptr;
	logic [CNT_W-1:0] count;
	logic       full, overwrite, link_ev, end_ev;
	logic       overwrite_flag, link_state_change_flag, packet_end_flag, receiver_event_flag, receiver_event_flag_q, thr_flag, thr_q;
	logic [2:0] pbs;
	logic [7:0] thr_lvl;
	logic       is_stuff, flag_hit, abort_hit, emit, byte_done;
	logic [7:0] raw_next, new_byte;

	// which first-byte values admit a frame
	function automatic logic addr_match(input logic [7:0] b, input logic mm,
		input logic [7:0] p, input logic [7:0] s);
		if (mm)
			addr_match = (b[7:2] == 6'h3f) || (b[7:2] == p[7:2]);
		else
			addr_match = (b == 8'hff) || (b == p) || (b == s);
	endfunction

	// reflected crc, one bit at a time
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
	endfunction

	assign wr_hit = i_sel & i_wr;
	assign rd_hit = i_sel & i_rd;
	assign st_rd = rd_hit && (i_ofs == OFS_STATUS);
	assign pop = rd_hit && (i_ofs == OFS_DATA) && (count != '0);
	assign flush = ~cfg_en | cfg_tr;
	assign full = (count == CNT_W'(DEPTH));
	assign overwrite = wr_req & full;
	assign link_ev = wr_req && !overwrite && (wr_word[10:8] == PBS_ACTIVE
		|| wr_word[10:8] == PBS_ABORT);
	assign end_ev = wr_req && !overwrite && wr_word[10];
	assign thr_lvl = (thr == 7'h00) ? THRESH_ZERO_LEVEL : {1'b0, thr};

	// line decode of the incoming bit
	assign raw_next = {i_bit, raw[7:1]};
	assign is_stuff = (ones == STUFF_ONES) && !i_bit;
	assign flag_hit = (raw_next == FLAG_BYTE);
	assign abort_hit = i_bit && (ones == ABORT_ONES);
	assign emit = in_frame && !is_stuff && (dcnt == 3'h7);
	assign new_byte = {dly[0], asm_byte[7:1]};
	assign byte_done = emit && (nbit == 3'h7);

	// configuration registers
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			{cfg_men, cfg_mm, cfg_tr, cfg_en} <= CONFIG_RST[3:0];
			{irq_output_enable, thr} <= CONFIG_RST;
			pa <= PATTERN_RST;
			sa <= PATTERN_RST;
		end else begin
			cfg_tr <= 1'b0;                            // restart is a pulse
			if (wr_hit && i_ofs == OFS_CONFIG) begin
				cfg_en <= i_wdata[CFG_EN_BIT];
				cfg_tr <= i_wdata[CFG_TR_BIT];
				cfg_mm <= i_wdata[CFG_MM_BIT];
				cfg_men <= i_wdata[CFG_MEN_BIT];
			end
			if (wr_hit && i_ofs == OFS_INTCTL) begin
				irq_output_enable <= i_wdata[ICTL_IRQ_OUTPUT_ENABLE_BIT];
				thr <= i_wdata[6:0];
			end
			if (wr_hit && i_ofs == OFS_PRIMARY)
				pa <= i_wdata;
			if (wr_hit && i_ofs == OFS_SECONDARY)
				sa <= i_wdata;
		end
	end

	// deframer: flags, aborts, zero deletion, bytes, fcs
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || flush) begin
			{ones, dcnt, nbit} <= '0;
			raw <= '0;
			dly <= '0;
			asm_byte <= '0;
			pend <= '0;
			crc <= CRC_INIT;
			{link_up, in_frame, drop, first, pend_v, wr_req} <= '0;
			wr_word <= '0;
		end else begin
			wr_req <= 1'b0;
			if (i_bit_valid) begin
				raw <= raw_next;
				ones <= i_bit ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
				if (abort_hit) begin
					// seven ones: frame dropped, link goes down
					if (link_up) begin
						wr_req <= 1'b1;
						wr_word <= {PBS_ABORT, 8'h00};
					end
					{link_up, in_frame, pend_v} <= '0;
					{dcnt, nbit} <= '0;
				end else if (flag_hit) begin
					if (!link_up) begin
						link_up <= 1'b1;
						wr_req <= 1'b1;
						wr_word <= {PBS_ACTIVE, 8'h00};
					end else if (in_frame && pend_v && !drop) begin
						wr_req <= 1'b1;
						wr_word <= {PBS_END[2], crc != CRC_GOOD, nbit != 3'h0, pend};
					end
					in_frame <= 1'b1;
					{dcnt, nbit} <= '0;
					{pend_v, drop} <= '0;
					first <= 1'b1;
					crc <= CRC_INIT;
				end else if (in_frame && !is_stuff) begin
					dly <= {i_bit, dly[6:1]};
					if (dcnt != 3'h7)
						dcnt <= dcnt + 3'h1;
					if (emit) begin
						asm_byte <= new_byte;               // first bit lands in bit 0
						crc <= crc_step(crc, dly[0]);
						nbit <= nbit + 3'h1;
					end
					if (byte_done) begin
						pend <= new_byte;
						pend_v <= 1'b1;
						if (first) begin
							first <= 1'b0;
							drop <= cfg_men && !addr_match(new_byte, cfg_mm, pa, sa);
						end
						if (pend_v && !drop) begin
							wr_req <= 1'b1;
							wr_word <= {PBS_DATA, pend};
						end
					end
				end
			end
		end
	end

	// fifo storage; a write to a full fifo discards everything
	always_ff @(posedge i_ref_clk) begin
		if (wr_req && !full)
			mem[wptr] <= wr_word;
	end

	// fifo pointers and fill
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || flush || overwrite) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (wr_req)
				wptr <= wptr + PTR_W'(1);
			if (pop)
				rptr <= rptr + PTR_W'(1);
			if (wr_req && !pop)
				count <= count + CNT_W'(1);
			else if (pop && !wr_req)
				count <= count - CNT_W'(1);
		end
	end

	// status of the byte last popped
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || flush)
			pbs <= PBS_DATA;
		else if (pop)
			pbs <= mem[rptr][10:8];
	end

	// sticky flags; a new event beats the read that clears
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || flush) begin
			{overwrite_flag, link_state_change_flag, packet_end_flag, receiver_event_flag, receiver_event_flag_q, thr_flag, thr_q} <= '0;
		end else begin
			overwrite_flag <= (overwrite_flag & ~st_rd) | overwrite;
			link_state_change_flag <= overwrite ? 1'b0 : (link_state_change_flag & ~st_rd) | link_ev;
			packet_end_flag <= overwrite ? 1'b0 : (packet_end_flag & ~st_rd) | end_ev;
			thr_flag <= (count == '0) ? 1'b0 : thr_flag | (count > thr_lvl);
			thr_q <= thr_flag;
			receiver_event_flag <= (receiver_event_flag & ~st_rd) | link_ev | end_ev | overwrite
				| (thr_flag & ~thr_q);
			receiver_event_flag_q <= receiver_event_flag;
		end
	end

	assign o_rise = receiver_event_flag & ~receiver_event_flag_q & irq_output_enable;

	// register read view
	always_comb begin
		o_rdata = 8'h00;
		case (i_ofs)
			OFS_CONFIG: o_rdata = {4'h0, cfg_men, cfg_mm, cfg_tr, cfg_en};
			OFS_INTCTL: o_rdata = {irq_output_enable, thr};
			OFS_STATUS: o_rdata = {count == '0, overwrite_flag, link_state_change_flag, packet_end_flag, pbs, receiver_event_flag};
			OFS_DATA: o_rdata = (count != '0) ? mem[rptr][7:0] : 8'h00;
			OFS_PRIMARY: o_rdata = pa;
			OFS_SECONDARY: o_rdata = sa;
			default: o_rdata = 8'h00;
		endcase
	end

	// checks
	chk_fe_empty: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(wr_req && !full && !flush) |=> (count != '0))
		else $error("fifo empty after a write");
	chk_ovr_reset: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(overwrite && !flush) |=> (overwrite_flag && !link_state_change_flag && !packet_end_flag && count == '0))
		else $error("overwrite did not reset fifo and flags");
	chk_link_set: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(link_ev && !flush) |=> link_state_change_flag ##0 (pbs == $past(pbs)))
		else $error("link change not flagged");
	chk_link_state_change_flag_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(st_rd && !link_ev) |=> !link_state_change_flag)
		else $error("link change survived its read");
	chk_packet_end_flag_set: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(end_ev && !flush) |=> packet_end_flag [*1] ##1 (packet_end_flag || $past(st_rd)))
		else $error("packet end not flagged");
	chk_pbs_pop: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(pop && !flush) |=> (pbs == $past(mem[rptr][10:8])))
		else $error("byte status does not follow popped byte");
	chk_receiver_event_flag_src: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		((link_ev || end_ev || overwrite) && !flush) |=> receiver_event_flag)
		else $error("event flag missed a source");
	chk_pop_count: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(pop && !wr_req && !flush) |=> (count == $past(count) - CNT_W'(1)))
		else $error("data read did not pop one byte");
	chk_pattern_rst: assert property (@(posedge i_ref_clk)
		i_srst |=> (pa == PATTERN_RST && sa == PATTERN_RST))
		else $error("match patterns not reset to ones");
	chk_thr_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(thr_flag && count != '0 && !flush) |=> thr_flag)
		else $error("threshold flag dropped early");
	chk_disable_clr: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!cfg_en |=> (count == '0 && !receiver_event_flag && !link_up))
		else $error("disabled receiver kept state");
	cov_overwrite: cover property (@(posedge i_ref_clk) overwrite);
	cov_good_end: cover property (@(posedge i_ref_clk) end_ev && wr_word[10:8] == PBS_END);
	cov_abort: cover property (@(posedge i_ref_clk) link_ev && wr_word[10:8] == PBS_ABORT);
endmodule

module hdlc_receive_status_fifo #(
	parameter int NUM_CHANNELS = 8,
	parameter int FIFO_DEPTH = 128
) (
	// clock and reset
	input  wire logic                             i_ref_clk,
	input  wire logic                             i_srst,
	// register port
	input  wire logic [hdlc_rx_pkg::ADDR_W-1:0]   i_addr,
	input  wire logic [hdlc_rx_pkg::DATA_W-1:0]   i_wdata,
	input  wire logic                             i_wr,
	input  wire logic                             i_rd,
	output logic      [hdlc_rx_pkg::DATA_W-1:0]   o_rdata,
	// received datalink bits, one stream per channel
	input  wire logic [NUM_CHANNELS-1:0]          i_dl_bit,
	input  wire logic [NUM_CHANNELS-1:0]          i_dl_valid,
	// interrupt
	output logic                                  o_int_n
);
	import hdlc_rx_pkg::*;
	localparam int CH_W = ADDR_W - OFS_W;

	logic [7:0]        sel_reg;                       // instance selector
	logic [CH_W-1:0]   chan;                          // channel from address
	logic [OFS_W-1:0]  ofs;
	logic              inst;                          // selected instance
	logic              chan_ok;                       // channel exists
	logic [NUM_CHANNELS*2-1:0][7:0] unit_rdata;
	logic [NUM_CHANNELS*2-1:0]      unit_rise;
	logic [NUM_CHANNELS-1:0][1:0]   irq_pend, irq_mask;
	logic [NUM_CHANNELS*2-1:0]      pend_flat, mask_flat;

	assign chan = i_addr[ADDR_W-1:OFS_W];
	assign ofs = i_addr[OFS_W-1:0];
	assign inst = sel_reg[SEL_LSB];
	assign chan_ok = (32'(chan) < NUM_CHANNELS);

	// one pair of receivers per channel
	for (genvar g = 0; g < NUM_CHANNELS * 2; g++) begin : g_unit
		hdlc_rx_unit #(.DEPTH(FIFO_DEPTH)) u_rx (
			.i_ref_clk   (i_ref_clk),
			.i_srst      (i_srst),
			.i_bit       (i_dl_bit[g/2]),
			.i_bit_valid (i_dl_valid[g/2]),
			.i_sel       (chan_ok && 32'(chan) == g / 2 && inst == 1'(g % 2)),
			.i_ofs       (ofs),
			.i_wr        (i_wr),
			.i_rd        (i_rd),
			.i_wdata     (i_wdata),
			.o_rdata     (unit_rdata[g]),
			.o_rise      (unit_rise[g])
		);
		assign pend_flat[g] = irq_pend[g/2][g%2];
		assign mask_flat[g] = irq_mask[g/2][g%2];
	end

	// selector register
	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			sel_reg <= CONFIG_RST;
		else if (i_wr && i_addr == OFS_SELECT)
			sel_reg <= {i_wdata[7:6], 6'h00};
	end

	// pending bits, write one to clear; a new edge wins
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			irq_pend <= '0;
			irq_mask <= '0;
		end else begin
			for (int c = 0; c < NUM_CHANNELS; c++) begin
				if (i_wr && chan_ok && 32'(chan) == c && ofs == OFS_IRQ_MASK)
					irq_mask[c] <= i_wdata[1:0];
				irq_pend[c] <= (irq_pend[c] & ~((i_wr && chan_ok && 32'(chan) == c
					&& ofs == OFS_IRQ_PEND) ? i_wdata[1:0] : 2'h0))
					| unit_rise[2*c +: 2];
			end
		end
	end

	// level interrupt, low while any unmasked bit pends
	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			o_int_n <= 1'b1;
		else
			o_int_n <= ~|(pend_flat & mask_flat);
	end

	// read data, valid in the cycle after the strobe
	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			o_rdata <= 8'h00;
		else if (i_rd) begin
			if (i_addr == OFS_SELECT)
				o_rdata <= sel_reg;
			else if (!chan_ok)
				o_rdata <= 8'h00;                         // unmapped reads zero
			else if (ofs == OFS_IRQ_PEND)
				o_rdata <= {6'h00, irq_pend[chan]};
			else if (ofs == OFS_IRQ_MASK)
				o_rdata <= {6'h00, irq_mask[chan]};
			else
				o_rdata <= unit_rdata[{chan, inst}];
		end
	end

	chk_irq_pin: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(|(pend_flat & mask_flat)) |=> !o_int_n)
		else $error("interrupt pin not asserted");
	chk_select_read: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_rd && i_addr == OFS_SELECT) |=> (o_rdata == $past(sel_reg)))
		else $error("selector read back wrong");
	cov_irq: cover property (@(posedge i_ref_clk) $fell(o_int_n));
endmodule
`default_nettype wire

/* dv/hdlc_bit_source.sv */
`timescale 1ns/100ps
`default_nettype none
module hdlc_bit_source (
	// clock
	input  wire logic i_ref_clk,
	// serial datalink toward the receiver
	output logic      o_bit,
	output logic      o_valid
);
	int          ones;   // run of ones since the last zero sent, data or stuffed
	logic [15:0] crc;    // running frame check value

	// idle line at time zero
	initial begin
		o_bit = 1'b0;
		o_valid = 1'b0;
		ones = 0;
		crc = 16'hffff;
	end

	// one bit, then a gap cycle; a released line shows the inverse, never the old value
	task automatic put_bit(input logic b);
		@(posedge i_ref_clk);
		o_bit <= b;
		o_valid <= 1'b1;
		@(posedge i_ref_clk);
		o_valid <= 1'b0;
		o_bit <= ~b;
	endtask

	// unstuffed byte, lsb first: flags and aborts
	task automatic put_raw(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			put_bit(v[i]);
		end
		ones = 0;
	endtask

	// data bit with check update and zero insertion after five ones
	task automatic put_data(input logic b);
		logic fb;
		fb = crc[0] ^ b;
		crc = crc >> 1;
		if (fb) begin
			crc = crc ^ 16'h8408;
		end
		put_bit(b);
		ones = b ? ones + 1 : 0;
		if (ones == 5) begin
			put_bit(1'b0);
			ones = 0;
		end
	endtask

	// frame: mode 0 good check, 1 corrupted check, 2 three odd bits after check
	task automatic send_frame(input logic [7:0] a, input int n, input int mode, input logic cl);
		logic [7:0]  v;
		logic [15:0] fcs;
		put_raw(8'h7e);
		crc = 16'hffff;
		for (int i = 0; i < n; i++) begin
			v = (i == 0) ? a : (8'hf8 ^ i[7:0]);
			for (int k = 0; k < 8; k++) begin
				put_data(v[k]);
			end
		end
		fcs = ~crc;
		if (mode == 1) begin
			fcs[0] = ~fcs[0];
		end
		for (int k = 0; k < 16; k++) begin
			put_data(fcs[k]);
		end
		if (mode == 2) begin
			for (int k = 0; k < 3; k++) begin
				put_data(k[0]);
			end
		end
		if (cl) begin
			put_raw(8'h7e);
		end
	endtask
endmodule
`default_nettype wire

/* dv/test_hdlc_receive_status_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module test_hdlc_receive_status_fifo;
	import hdlc_rx_pkg::*;
	localparam int NCH = 8;
	localparam int DEPTH = 16;   // small fifo so overflow comes quickly
	localparam logic [7:0] ENDC [3] = '{8'h04, 8'h06, 8'h07};
	localparam logic [7:0] MADR [6] = '{8'h43, 8'h42, 8'h24, 8'hff, 8'h41, 8'h24};
	localparam logic [7:0] MCFG [6] = '{8'h09, 8'h09, 8'h09, 8'h09, 8'h0d, 8'h0d};
	localparam logic [7:0] MCNT [6] = '{8'h00, 8'h05, 8'h05, 8'h05, 8'h05, 8'h00};
	logic                 i_ref_clk;
	logic                 i_srst;
	logic [ADDR_W-1:0]    i_addr;
	logic [DATA_W-1:0]    i_wdata;
	logic                 i_wr;
	logic                 i_rd;
	logic [DATA_W-1:0]    o_rdata;
	logic [NCH-1:0]       i_dl_bit;
	logic [NCH-1:0]       i_dl_valid;
	logic                 o_int_n;
	logic                 src_bit;
	logic                 src_valid;
	int                   err_total;
	int                   comparisons;
	int                   m;
	logic [7:0]           d;
	logic [7:0]           q[$];   // bytes popped by the last drain
	logic [2:0]           pbs;

	// only channel 0 carries traffic
	assign i_dl_bit = {{(NCH-1){1'b0}}, src_bit};
	assign i_dl_valid = {{(NCH-1){1'b0}}, src_valid};

	hdlc_receive_status_fifo #(.NUM_CHANNELS(NCH), .FIFO_DEPTH(DEPTH)) hdlc_receive_status_fifo_inst (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_addr    (i_addr),
		.i_wdata   (i_wdata),
		.i_wr      (i_wr),
		.i_rd      (i_rd),
		.o_rdata   (o_rdata),
		.i_dl_bit  (i_dl_bit),
		.i_dl_valid(i_dl_valid),
		.o_int_n   (o_int_n)
	);

	hdlc_bit_source hdlc_bit_source_inst (
		.i_ref_clk(i_ref_clk),
		.o_bit    (src_bit),
		.o_valid  (src_valid)
	);

	// 25 MHz clock
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	function automatic logic [9:0] ad(input int ch, input logic [6:0] o);
		return {ch[2:0], o};
	endfunction

	// payload byte i of a frame addressed to a
	function automatic logic [7:0] pb(input logic [7:0] a, input int i);
		return (i == 0) ? a : (8'hf8 ^ i[7:0]);
	endfunction

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		comparisons++;
		if (got !== ex) begin
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
			err_total++;
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	// read data appear in the cycle after the strobe and hold until the next read
	task automatic rd(input logic [9:0] a, output logic [7:0] v);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask

	// pop until empty; status after the last pop gives its code
	task automatic drain(output logic [2:0] last);
		logic [7:0] s;
		logic [7:0] v;
		int         n;
		q.delete();
		for (n = 0; n < 40; n++) begin
			rd(ad(0, OFS_STATUS), s);
			last = s[3:1];
			if (s[7])
				break;
			repeat (15) @(posedge i_ref_clk);
			rd(ad(0, OFS_DATA), v);
			q.push_back(v);
		end
		if (n == 40) begin
			err_total++;
			results();
		end
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge i_ref_clk);
		err_total++;
		results();
	end

	initial begin
		i_srst = 1'b1;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		err_total = 0;
		comparisons = 0;
		repeat (10) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		// reset values and channel decoding
		rd(ad(0, OFS_PRIMARY), d);
		chk("primary", 8'hff, d);
		rd(ad(0, OFS_SECONDARY), d);
		chk("secondary", 8'hff, d);
		rd(ad(0, OFS_STATUS), d);
		chk("empty", 8'h80, d & 8'hf1);
		rd(ad(0, 7'h7f), d);
		chk("unmapped", 8'h00, d);
		wr(ad(3, OFS_PRIMARY), 8'h3c);
		rd(ad(3, OFS_PRIMARY), d);
		chk("ch3 primary", 8'h3c, d);
		rd(ad(0, OFS_PRIMARY), d);
		chk("ch0 primary", 8'hff, d);
		// link activation with the pin enabled and unmasked
		wr(ad(0, OFS_INTCTL), 8'h80);
		wr(ad(0, OFS_IRQ_MASK), 8'h03);
		wr(ad(0, OFS_CONFIG), 8'h01);
		hdlc_bit_source_inst.put_raw(FLAG_BYTE);
		settle(6);
		chk("pin low", 8'h00, {7'h00, o_int_n});
		wr(ad(0, OFS_IRQ_PEND), 8'h03);
		settle(4);
		chk("pin high", 8'h01, {7'h00, o_int_n});
		rd(ad(0, OFS_STATUS), d);
		chk("link up", 8'h21, d);
		drain(pbs);
		chk("up code", {5'h00, PBS_ACTIVE}, {5'h00, pbs});
		rd(ad(0, OFS_STATUS), d);
		chk("flags cleared", 8'h80, d & 8'hf1);
		// one frame of each ending kind, pin masked
		wr(ad(0, OFS_IRQ_MASK), 8'h00);
		for (m = 0; m < 3; m++) begin
			hdlc_bit_source_inst.send_frame(8'hff, 3, m, 1'b1);
			settle(4);
			rd(ad(0, OFS_STATUS), d);
			chk("packet end", 8'h11, d & 8'hf1);
			chk("pin masked", 8'h01, {7'h00, o_int_n});
			drain(pbs);
			chk("end code", ENDC[m], {5'h00, pbs});
			for (int k = 0; k < 3; k++) begin
				chk("byte", pb(8'hff, k), q[k]);
			end
		end
		// abort takes the link down
		hdlc_bit_source_inst.put_raw(8'h7f);
		settle(4);
		rd(ad(0, OFS_STATUS), d);
		chk("abort change", 8'h20, d & 8'h20);
		drain(pbs);
		chk("abort code", {5'h00, PBS_ABORT}, {5'h00, pbs});
		// address filter in both compare modes
		wr(ad(0, OFS_PRIMARY), 8'h42);
		wr(ad(0, OFS_SECONDARY), 8'h24);
		hdlc_bit_source_inst.put_raw(FLAG_BYTE);
		drain(pbs);
		for (m = 0; m < 6; m++) begin
			wr(ad(0, OFS_CONFIG), MCFG[m]);
			hdlc_bit_source_inst.send_frame(MADR[m], 3, 0, 1'b1);
			settle(4);
			drain(pbs);
			chk("match count", MCNT[m], 8'(q.size()));
		end
		// overflow of an unread fifo, then disable
		wr(ad(0, OFS_CONFIG), 8'h01);
		hdlc_bit_source_inst.send_frame(8'hff, DEPTH + 4, 0, 1'b0);
		rd(ad(0, OFS_STATUS), d);
		chk("overwrite", 8'h40, d & 8'h70);
		rd(ad(0, OFS_STATUS), d);
		chk("overwrite read", 8'h00, d & 8'h40);
		// restart pulse empties the bytes left after the overwrite
		rd(ad(0, OFS_STATUS), d);
		chk("left bytes", 8'h00, d & 8'h80);
		wr(ad(0, OFS_CONFIG), 8'h03);
		rd(ad(0, OFS_STATUS), d);
		chk("restart", 8'h80, d & 8'hf1);
		wr(ad(0, OFS_CONFIG), 8'h00);
		rd(ad(0, OFS_STATUS), d);
		chk("disabled", 8'h80, d & 8'hf1);
		// second receiver unit behind the selector
		wr(OFS_SELECT, 8'h40);
		rd(ad(0, OFS_PRIMARY), d);
		chk("second unit", 8'hff, d);
		wr(OFS_SELECT, 8'h00);
		rd(ad(0, OFS_PRIMARY), d);
		chk("first unit", 8'h42, d);
		results();
	end
endmodule
`default_nettype wire
